// [common/prl_params.svh]
// Register offsets, field positions, reset values and timing counts of the ramp limiter
`ifndef PRL_PARAMS_SVH
`define PRL_PARAMS_SVH

// Register offsets
`define PRL_OFS_OUT1_CFG 8'h5C
`define PRL_OFS_OUT2_CFG 8'h5D
`define PRL_OFS_OUT3_CFG 8'h5E
`define PRL_OFS_RAMP_A 8'h62
`define PRL_OFS_RAMP_B 8'h63
`define PRL_OFS_DUTY1 8'h30
`define PRL_OFS_DUTY2 8'h31
`define PRL_OFS_DUTY3 8'h32

// Field positions
`define PRL_BIT_SLOW 3
`define PRL_BIT_EN_OUT1 3
`define PRL_BIT_EN_OUT2 7
`define PRL_BIT_EN_OUT3 3
`define PRL_LSB_STEP_OUT1 0
`define PRL_LSB_STEP_OUT2 4
`define PRL_LSB_STEP_OUT3 0

// Reset values
`define PRL_RST_CFG 8'h00
`define PRL_RST_RAMP 8'h00
`define PRL_RST_DUTY 8'h00

// Timing: one update per 35 s / 255 slots, in microseconds
`define PRL_CLK_MHZ 25
`define PRL_UPDATE_PERIOD_US 137255
`define PRL_UPDATE_CYCLES (`PRL_UPDATE_PERIOD_US * `PRL_CLK_MHZ)
`define PRL_SLOW_DIV 4

`endif

// [common/prl_pkg.sv]
// Types shared by the ramp limiter
package prl_pkg;
    typedef logic [7:0] prl_byte_t;
    typedef logic [2:0] prl_step_code_t;
    typedef logic [1:0] prl_slow_cnt_t;
endpackage

// [hdl/prl_ramp_limiter.sv]
// Duty ramp limiter for three fan drive outputs with its register file
// What this block does
// [RULE_01] Bit 3 of ramp control A enables ramp limiting on output 1.
// [RULE_02] Bit 7 of ramp control B enables ramp limiting on output 2.
// [RULE_03] Bit 3 of ramp control B enables ramp limiting on output 3.
// [RULE_04] Period holds 255 slots; one slot is the duty and step unit.
// [RULE_05] Step codes 0..7 give 1,2,3,5,8,12,24,48 slots.
// [RULE_06] Output 1 step code sits in bits 2:0 of ramp control A.
// [RULE_07] Output 3 step code sits in bits 2:0 of ramp control B.
// [RULE_08] Output 2 step code sits in bits 6:4 of ramp control B.
// [RULE_09] Target above previous duty raises previous by one step at most.
// [RULE_10] Target below previous duty lowers previous by one step at most.
// [RULE_11] Result is stored as previous duty and driven on the output.
// [RULE_12] Config bit 3 of each output slows its ramp four times.
// [RULE_13] Slowed full ramp times run from 140 s down to 3.3 s.
// [RULE_14] Each output ramps independently of the others.
// [RULE_15] Without ramp limiting the duty follows the target on each update.
// [RULE_16] Small gaps land exactly on target; duty stays within 0 to 255.
// [RULE_17] One ramp update per fixed update tick.
`timescale 1ns/1ps
`include "prl_params.svh"

module prl_ramp_limiter #(
    parameter int UPDATE_CYCLES = `PRL_UPDATE_CYCLES,
    parameter int NUM_OUT = 3
) (
    // Clock, reset and enable
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire prl_pkg::prl_byte_t REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output prl_pkg::prl_byte_t REG_RDATA,
    // Duty targets from the automatic control loop
    input wire prl_pkg::prl_byte_t TARGET_DUTY_A,
    input wire prl_pkg::prl_byte_t TARGET_DUTY_B,
    input wire prl_pkg::prl_byte_t TARGET_DUTY_C,
    // Limited duty to the fan drive generators
    output prl_pkg::prl_byte_t FAN_DRIVE_OUT_A,
    output prl_pkg::prl_byte_t FAN_DRIVE_OUT_B,
    output prl_pkg::prl_byte_t FAN_DRIVE_OUT_C,
    // One-cycle marker of each update
    output logic UPDATE_TICK
);
    import prl_pkg::*;

    localparam int TICK_W = $clog2(UPDATE_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(UPDATE_CYCLES - 1);

    // Refuse settings the logic cannot serve
    initial begin
        if (UPDATE_CYCLES < 1) begin
            $error("UPDATE_CYCLES must be at least one");
        end
        if (NUM_OUT != 3) begin
            $error("NUM_OUT must be three");
        end
        // The slowdown counter is two bits wide
        if (`PRL_SLOW_DIV != 4) begin
            $error("Slowdown divider must be four");
        end
    end

    // Register place of one byte address; zero when off the map
    function automatic logic [3:0] reg_place(input logic [7:0] addr);
        logic [3:0] p;
        p = 4'h0;
        unique case (addr)
            `PRL_OFS_OUT1_CFG: p = 4'h1;
            `PRL_OFS_OUT2_CFG: p = 4'h2;
            `PRL_OFS_OUT3_CFG: p = 4'h3;
            `PRL_OFS_RAMP_A: p = 4'h4;
            `PRL_OFS_RAMP_B: p = 4'h5;
            `PRL_OFS_DUTY1: p = 4'h6;
            `PRL_OFS_DUTY2: p = 4'h7;
            `PRL_OFS_DUTY3: p = 4'h8;
            default: p = 4'h0;
        endcase
        return p;
    endfunction

    // Step code to slot count
    function automatic prl_byte_t step_slots(input prl_step_code_t code);
        prl_byte_t s;
        s = 8'h01;
        unique case (code)
            3'h0: s = 8'h01;
            3'h1: s = 8'h02;
            3'h2: s = 8'h03;
            3'h3: s = 8'h05;
            3'h4: s = 8'h08;
            3'h5: s = 8'h0C;
            3'h6: s = 8'h18;
            3'h7: s = 8'h30;
        endcase
        return s; // RULE_05
    endfunction

    // One ramp step from previous toward target
    function automatic prl_byte_t ramp_step(input prl_byte_t prev, input prl_byte_t tgt,
                                            input prl_byte_t step);
        logic [8:0] gap;
        prl_byte_t r;
        gap = 9'h000;
        r = prev;
        if (tgt > prev) begin
            gap = {1'b0, tgt} - {1'b0, prev};
            if (gap <= {1'b0, step}) begin
                r = tgt; // RULE_16
            end else begin
                r = prev + step; // RULE_09
            end
        end else if (tgt < prev) begin
            gap = {1'b0, prev} - {1'b0, tgt};
            if (gap <= {1'b0, step}) begin
                r = tgt; // RULE_16
            end else begin
                r = prev - step; // RULE_10
            end
        end
        return r;
    endfunction

    // Register file state
    prl_byte_t cfg_q [NUM_OUT];
    prl_byte_t cfg_d [NUM_OUT];
    prl_byte_t ramp_a_q, ramp_a_d;
    prl_byte_t ramp_b_q, ramp_b_d;
    prl_byte_t rdata_q, rdata_d;

    // Update tick state
    logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;

    // Per-output ramp state
    prl_byte_t duty_q [NUM_OUT];
    prl_byte_t duty_d [NUM_OUT];
    prl_slow_cnt_t slow_q [NUM_OUT];
    prl_slow_cnt_t slow_d [NUM_OUT];

    // Decoded controls per output
    prl_byte_t target [NUM_OUT];
    logic ramp_en [NUM_OUT];
    prl_step_code_t step_code [NUM_OUT];
    logic slow_en [NUM_OUT];

    // Route targets and decode control fields
    always_comb begin
        target[0] = TARGET_DUTY_A;
        target[1] = TARGET_DUTY_B;
        target[2] = TARGET_DUTY_C;
        ramp_en[0] = ramp_a_q[`PRL_BIT_EN_OUT1]; // RULE_01
        ramp_en[1] = ramp_b_q[`PRL_BIT_EN_OUT2]; // RULE_02
        ramp_en[2] = ramp_b_q[`PRL_BIT_EN_OUT3]; // RULE_03
        step_code[0] = ramp_a_q[`PRL_LSB_STEP_OUT1 +: 3]; // RULE_06
        step_code[1] = ramp_b_q[`PRL_LSB_STEP_OUT2 +: 3]; // RULE_08
        step_code[2] = ramp_b_q[`PRL_LSB_STEP_OUT3 +: 3]; // RULE_07
        slow_en[0] = cfg_q[0][`PRL_BIT_SLOW]; // RULE_12
        slow_en[1] = cfg_q[1][`PRL_BIT_SLOW]; // RULE_12
        slow_en[2] = cfg_q[2][`PRL_BIT_SLOW]; // RULE_12
    end

    // Register writes and read data
    always_comb begin
        cfg_d = cfg_q;
        ramp_a_d = ramp_a_q;
        ramp_b_d = ramp_b_q;
        rdata_d = 8'h00;
        // Writes land in the addressed register; duty places ignore them
        if (REG_WR) begin
            unique case (reg_place(REG_ADDR))
                4'h1: cfg_d[0] = REG_WDATA;
                4'h2: cfg_d[1] = REG_WDATA;
                4'h3: cfg_d[2] = REG_WDATA;
                4'h4: ramp_a_d = REG_WDATA;
                4'h5: ramp_b_d = REG_WDATA;
                default: ;
            endcase
        end
        // Reads return zero off the map; data stand one cycle only
        if (REG_RD) begin
            unique case (reg_place(REG_ADDR))
                4'h1: rdata_d = cfg_q[0];
                4'h2: rdata_d = cfg_q[1];
                4'h3: rdata_d = cfg_q[2];
                4'h4: rdata_d = ramp_a_q;
                4'h5: rdata_d = ramp_b_q;
                4'h6: rdata_d = duty_q[0];
                4'h7: rdata_d = duty_q[1];
                4'h8: rdata_d = duty_q[2];
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                cfg_q[i] <= `PRL_RST_CFG;
            end
            ramp_a_q <= `PRL_RST_RAMP;
            ramp_b_q <= `PRL_RST_RAMP;
            rdata_q <= 8'h00;
        end else if (CE) begin
            cfg_q <= cfg_d;
            ramp_a_q <= ramp_a_d;
            ramp_b_q <= ramp_b_d;
            rdata_q <= rdata_d;
        end
    end

    // Fixed-rate update tick
    // The tick is registered, so duties move one edge after it shows.
    // Target changes between ticks are seen by the ramp only at the next tick.
    // While CE is low the counter freezes and the interval stretches.
    always_comb begin
        tick_d = 1'b0;
        tick_cnt_d = tick_cnt_q + TICK_W'(1);
        if (tick_cnt_q >= TICK_LAST) begin
            tick_cnt_d = '0;
            tick_d = 1'b1; // RULE_17
        end
    end

    // Update tick flops
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (CE) begin
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
        end
    end

    // Independent ramp channel per output
    // Each channel keeps its own slowdown count, so sharing a target
    // between outputs never couples their ramps.
    // The slowdown count restarts whenever slowing or ramping is off,
    // so the first slowed step comes on the fourth tick after enabling.
    for (genvar g = 0; g < NUM_OUT; g++) begin : g_chan
        logic step_now;

        // Next duty and slowdown count
        always_comb begin
            duty_d[g] = duty_q[g];
            slow_d[g] = slow_q[g];
            step_now = 1'b0;
            if (tick_q) begin
                if (!ramp_en[g]) begin
                    duty_d[g] = target[g]; // RULE_15
                    slow_d[g] = '0;
                end else begin
                    // Slowed ramp moves on every fourth tick only
                    if (slow_en[g]) begin
                        slow_d[g] = slow_q[g] + 2'd1;
                        step_now = (slow_q[g] == 2'(`PRL_SLOW_DIV - 1)); // RULE_13
                    end else begin
                        slow_d[g] = '0;
                        step_now = 1'b1;
                    end
                    if (step_now) begin
                        // Step in 1/255 slots toward target
                        duty_d[g] = ramp_step(duty_q[g], target[g],
                                              step_slots(step_code[g])); // RULE_04
                    end
                end
            end
        end

        // Stored previous duty drives the output
        always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
                duty_q[g] <= `PRL_RST_DUTY;
                slow_q[g] <= '0;
            end else if (CE) begin
                duty_q[g] <= duty_d[g]; // RULE_11 RULE_14
                slow_q[g] <= slow_d[g];
            end
        end
    end

    // Outputs straight from flops
    // No logic sits between the flops and the pins, so the duty seen by
    // the drive generators never glitches between updates.
    assign REG_RDATA = rdata_q;
    assign FAN_DRIVE_OUT_A = duty_q[0]; // RULE_11
    assign FAN_DRIVE_OUT_B = duty_q[1];
    assign FAN_DRIVE_OUT_C = duty_q[2];
    assign UPDATE_TICK = tick_q;

endmodule

// [tb/prl_ramp_limiter_assertions.sv]
// Port-level checks of the ramp limiter
`timescale 1ns/1ps
module prl_ramp_limiter_assertions #(parameter int UPDATE_CYCLES = 8) (
    // Clock, reset, enable
    input logic CLK,
    input logic RST,
    input logic CE,
    // Register port
    input logic [7:0] REG_ADDR,
    input prl_pkg::prl_byte_t REG_WDATA,
    input logic REG_WR,
    input logic REG_RD,
    input prl_pkg::prl_byte_t REG_RDATA,
    // Duties
    input prl_pkg::prl_byte_t TARGET_DUTY_A,
    input prl_pkg::prl_byte_t TARGET_DUTY_B,
    input prl_pkg::prl_byte_t TARGET_DUTY_C,
    input prl_pkg::prl_byte_t FAN_DRIVE_OUT_A,
    input prl_pkg::prl_byte_t FAN_DRIVE_OUT_B,
    input prl_pkg::prl_byte_t FAN_DRIVE_OUT_C,
    input logic UPDATE_TICK
);
    import prl_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // New duty lies between the old duty and the target
    function automatic bit btw(prl_byte_t o, prl_byte_t p, prl_byte_t t);
        return (p <= t) ? (o >= p && o <= t) : (o <= p && o >= t);
    endfunction
    a_tick_period: assert property (
        UPDATE_TICK |=> !UPDATE_TICK [*7] ##1 UPDATE_TICK) else $error("tick spacing");
    a_hold_a: assert property (
        !UPDATE_TICK |=> $stable(FAN_DRIVE_OUT_A)) else $error("duty a moved");
    a_hold_bc: assert property (
        !UPDATE_TICK |=> $stable(FAN_DRIVE_OUT_B) && $stable(FAN_DRIVE_OUT_C))
        else $error("duty b or c moved");
    a_toward_a: assert property (
        UPDATE_TICK |=> btw(FAN_DRIVE_OUT_A, $past(FAN_DRIVE_OUT_A), $past(TARGET_DUTY_A)))
        else $error("duty a overshoot");
    a_toward_b: assert property (
        UPDATE_TICK |=> btw(FAN_DRIVE_OUT_B, $past(FAN_DRIVE_OUT_B), $past(TARGET_DUTY_B)))
        else $error("duty b overshoot");
    a_toward_c: assert property (
        UPDATE_TICK |=> btw(FAN_DRIVE_OUT_C, $past(FAN_DRIVE_OUT_C), $past(TARGET_DUTY_C)))
        else $error("duty c overshoot");
    a_read_duty: assert property (
        REG_RD && REG_ADDR == 8'h30 |=> REG_RDATA == $past(FAN_DRIVE_OUT_A))
        else $error("duty readback");
    a_ctrl_b_back: assert property (
        REG_WR && REG_ADDR == 8'h63 ##1 REG_RD && REG_ADDR == 8'h63
        |=> REG_RDATA == $past(REG_WDATA, 2)) else $error("ramp b readback");
endmodule

// [tb/prl_fan_model.sv]
// Behavioural fans loaded by the three limited duties
`timescale 1ns/1ps
module prl_fan_model (
    // Clock
    input logic clk,
    // Duty from the limiter
    input prl_pkg::prl_byte_t duty_a,
    input prl_pkg::prl_byte_t duty_b,
    input prl_pkg::prl_byte_t duty_c,
    // Any fan turning
    output logic spinning
);
    import prl_pkg::*;
    // A fan turns while its duty is above zero
    always_ff @(posedge clk) spinning <= |{duty_a, duty_b, duty_c};
endmodule

// [tb/pwm_duty_ramp_limiter_test.sv]
// Self-checking bench of the ramp limiter
`timescale 1ns/1ps
module pwm_duty_ramp_limiter_test;
    import prl_pkg::*;
    logic CLK = 0, RST = 1, CE = 1, REG_WR = 0, REG_RD = 0, UPDATE_TICK;
    logic [7:0] REG_ADDR = 0;
    prl_byte_t REG_WDATA = 0, TARGET_DUTY_A = 0, TARGET_DUTY_B = 0, TARGET_DUTY_C = 0;
    prl_byte_t REG_RDATA, FAN_DRIVE_OUT_A, FAN_DRIVE_OUT_B, FAN_DRIVE_OUT_C, d;
    prl_byte_t ex [3] = '{0, 0, 0}, tg [3] = '{0, 0, 0}, cf [5];
    int cnt [3] = '{0, 0, 0}, bad_count = 0, comparisons = 0;
    logic [7:0] adr [5] = '{8'h5C, 8'h5D, 8'h5E, 8'h62, 8'h63};
    prl_byte_t tbl [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
    always #20 CLK = ~CLK;
    prl_ramp_limiter #(.UPDATE_CYCLES(8)) i_dut (.*);
    prl_fan_model i_fan (.clk(CLK), .duty_a(FAN_DRIVE_OUT_A), .duty_b(FAN_DRIVE_OUT_B),
        .duty_c(FAN_DRIVE_OUT_C), .spinning());
    task chk(string n, prl_byte_t e, prl_byte_t g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(logic [7:0] a, prl_byte_t v);
        // Strobe stays up into a following write; the next task or tick lowers it
        REG_ADDR <= a;
        REG_WDATA <= v;
        REG_RD <= 0;
        REG_WR <= 1;
        @(posedge CLK);
    endtask
    task rd(logic [7:0] a, output prl_byte_t v);
        REG_ADDR <= a;
        REG_WR <= 0;
        REG_RD <= 1;
        @(posedge CLK);
        REG_RD <= 0;
        #1 v = REG_RDATA;
        @(posedge CLK);
    endtask
    // Wait for the update pulse, then past the edge that applies it
    task tick();
        int n;
        n = 0;
        REG_WR <= 0;
        #1;
        while (UPDATE_TICK !== 1'b1 && n < 20) begin @(posedge CLK); #1; n++; end
        if (n == 20) bad_count++;
        @(posedge CLK);
        @(posedge CLK);
    endtask
    // One step toward the target, landing on it when close
    function automatic prl_byte_t nxt(prl_byte_t p, prl_byte_t t, prl_byte_t s);
        if (t > p) return (t - p > s) ? p + s : t;
        return (p - t > s) ? p - s : t;
    endfunction
    // Reference update of one output
    task upd(int i, logic en, prl_step_code_t c);
        if (!en) begin ex[i] = tg[i]; cnt[i] = 0; end
        else if (!cf[i][3]) begin ex[i] = nxt(ex[i], tg[i], tbl[c]); cnt[i] = 0; end
        else begin
            if (cnt[i] == 3) ex[i] = nxt(ex[i], tg[i], tbl[c]);
            cnt[i] = (cnt[i] + 1) % 4;
        end
    endtask
    // One observed update: reference model against the three outputs
    task apply();
        tick();
        upd(0, cf[3][3], cf[3][2:0]);
        upd(1, cf[4][7], cf[4][6:4]);
        upd(2, cf[4][3], cf[4][2:0]);
        chk("out a", ex[0], FAN_DRIVE_OUT_A);
        chk("out b", ex[1], FAN_DRIVE_OUT_B);
        chk("out c", ex[2], FAN_DRIVE_OUT_C);
    endtask
    task give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(63));
        repeat (16) @(posedge CLK);
        RST <= 0;
        @(posedge CLK);
        // Reset values, readback, unmapped and read-only places
        for (int i = 0; i < 5; i++) begin
            rd(adr[i], d); chk("reset", 8'h00, d);
            wr(adr[i], 8'($urandom)); rd(adr[i], d); chk("readback", REG_WDATA, d);
        end
        rd(8'h00, d); chk("unmapped", 8'h00, d);
        wr(8'h30, 8'hA5); rd(8'h30, d); chk("duty ro", 8'h00, d);
        for (int i = 0; i < 5; i++) begin cf[i] = 0; wr(adr[i], 8'h00); end
        tick();
        $display("registers done");
        // Random targets with corners, every step code on every output
        for (int it = 0; it < 48; it++) begin
            if (it % 6 == 0) begin
                apply();
                for (int i = 0; i < 5; i++) cf[i] = 8'($urandom);
                cf[3][2:0] = 3'(it / 6); cf[4][6:4] = 3'(it / 6 + 3); cf[4][2:0] = 3'(it / 6 + 5);
                for (int i = 0; i < 5; i++) wr(adr[i], cf[i]);
            end
            for (int i = 0; i < 3; i++)
                tg[i] = ($urandom % 4 == 0) ? {8{1'($urandom)}} : 8'($urandom);
            TARGET_DUTY_A <= tg[0]; TARGET_DUTY_B <= tg[1]; TARGET_DUTY_C <= tg[2];
            apply();
            rd(8'(8'h30 + it % 3), d); chk("duty reg", ex[it % 3], d);
        end
        $display("ramp done");
        give_verdict();
    end
endmodule
bind prl_ramp_limiter prl_ramp_limiter_assertions #(.UPDATE_CYCLES(UPDATE_CYCLES)) i_chk (.*);
